// ==== src/hcr_pkg.sv ====
// constants and carrier types for the host configuration register pair
// assumes a single 50 MHz system clock and an external page-select source
// Overview of operation
// (RL1) On page zero, a read of offset 0ah returns the io_and_irq_setup register.
// (RL2) A read of 0ah followed directly by a write of 0ah updates io_and_irq_setup.
// (RL3) A write of 0ah with no read of 0ah just before it goes to remote_count_low.
// (RL4) On page zero, a read of offset 0bh returns the media_and_bus_setup register.
// (RL5) A read of 0bh followed directly by a write of 0bh updates media_and_bus_setup.
// (RL6) A write of 0bh with no read of 0bh just before it goes to remote_count_high.
// (RL7) The io base is 300h, or 200h when bit 3 is set, plus 20h times bits 2..0.
// (RL8) Exactly one of eight irq lines carries the interrupt, picked by bits 6..4.
// (RL9) With bit 7 set in remote read mode the next read data is fetched early.
// (RL10) Bits 1..0 pick the medium: 00 twisted pair, 10 coax enabled, 11 automatic.
// (RL11) Bit 2 of media_and_bus_setup reads one for a good link and zero for a fail.
// (RL12) Bit 4 low pulls iochrdy after the command strobe, high after bale rises.
// (RL13) Bit 5 is set when wait states were inserted but the host ended the cycle.
// (RL14) The host selects page zero in the command register before these accesses.
// (RL15) A read of 0ah or 0bh arms a flag that any other register access clears.
// (RL16) Reserved bits of media_and_bus_setup read zero and ignore writes.
package hcr_pkg;

    // register offsets
    localparam logic [3:0] OFS_IO_AND_IRQ_SETUP    = 4'ha;
    localparam logic [3:0] OFS_MEDIA_AND_BUS_SETUP = 4'hb;
    localparam logic [1:0] PAGE_ZERO               = 2'h0;

    // io_and_irq_setup fields
    localparam int         IO_BASE_SEL_HI  = 3;
    localparam int         IRQ_SEL_LSB     = 4;
    localparam int         EARLY_FETCH_BIT = 7;
    localparam logic [7:0] IO_IRQ_RESET    = 8'h00;

    // media_and_bus_setup fields
    localparam int         MEDIA_SEL_LSB   = 0;
    localparam int         LINK_GOOD_BIT   = 2;
    localparam int         WAIT_TIMING_BIT = 4;
    localparam int         CYCLE_ERR_BIT   = 5;
    localparam logic [7:0] MEDIA_WR_MASK   = 8'h13;
    localparam logic [7:0] MEDIA_RESET     = 8'h00;

    // io base decode
    localparam logic [9:0] IO_BASE_HIGH = 10'h300;
    localparam logic [9:0] IO_BASE_LOW  = 10'h200;

    // medium codes
    localparam logic [1:0] MEDIA_TWISTED = 2'h0;
    localparam logic [1:0] MEDIA_COAX    = 2'h2;
    localparam logic [1:0] MEDIA_AUTO    = 2'h3;

    // register access request from the host bus front end
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [1:0] page;
        logic [3:0] addr;
        logic [7:0] wdata;
    } hcr_req_type;

    // redirected remote byte count writes
    typedef struct packed {
        logic       low_stb;
        logic       high_stb;
        logic [7:0] data;
    } hcr_cnt_wr_type;

endpackage

// ==== src/hcr_pin_sync.sv ====
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to i_sys_clk
`timescale 1ns/1ps
module hcr_pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // pin and filtered level
    input  wire logic i_pin,
    output logic      o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // first stage feeds only the second, to keep metastability contained
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s1_q <= RESET_LEVEL;
            s2_q <= RESET_LEVEL;
            s3_q <= RESET_LEVEL;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_level <= RESET_LEVEL;
        end else if (s2_q == s3_q) begin
            o_level <= s3_q;
        end
    end
endmodule

// ==== src/hcr_irq_route.sv ====
// routes one interrupt request onto one of eight lines by a 3-bit code
// assumes request and code are on i_sys_clk
`timescale 1ns/1ps
module hcr_irq_route #(
    parameter int LINES = 8
) (
    // clock and reset
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst,
    // request and selection
    input  wire logic                     i_request,
    input  wire logic [$clog2(LINES)-1:0] i_sel,
    // registered one-hot lines
    output logic      [LINES-1:0]         o_lines
);
    // only the selected line can go active, never two at once
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_lines <= '0;
        end else begin
            o_lines <= i_request ? (LINES'(1) << i_sel) : '0;
        end
    end
endmodule

// ==== src/hcr_config_regs.sv ====
// host-visible configuration register pair sharing offsets with remote count
// assumes one-cycle rd/wr pulses from the host bus front end on i_sys_clk,
// page taken from the command register, ISA strobes arriving as raw pins
`timescale 1ns/1ps
module hcr_config_regs (
    // clock and reset
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst,
    // register access
    input  wire hcr_pkg::hcr_req_type    i_req,
    output logic [7:0]                   o_reg_rdata,
    output logic                         o_reg_rvalid,
    output hcr_pkg::hcr_cnt_wr_type      o_cnt_wr,
    // io base and interrupt routing
    output logic [9:0]                   o_io_base,
    input  wire logic                    i_irq_request,
    output logic [7:0]                   o_irq_lines,
    // remote read early fetch
    input  wire logic                    i_remote_read_mode,
    input  wire logic                    i_port_read_done,
    output logic                         o_early_fetch_req,
    // medium selection and link
    input  wire logic                    i_auto_coax_detect,
    input  wire logic                    i_link_good_pin,
    output logic [1:0]                   o_media_sel,
    output logic                         o_coax_enable_out,
    // isa wait-state control
    input  wire logic                    i_bale_pin,
    input  wire logic                    i_ior_n_pin,
    input  wire logic                    i_iow_n_pin,
    input  wire logic                    i_need_wait,
    output logic                         o_iochrdy_out,
    output logic                         o_iochrdy_oe
);
    logic [7:0] io_and_irq_setup_q;
    logic [7:0] media_and_bus_setup_q;
    logic       armed_low_q;
    logic       armed_high_q;
    logic       link_good_flag;
    logic       bale_lvl;
    logic       ior_n_lvl;
    logic       iow_n_lvl;
    logic       bale_prev_q;
    logic       cmd_prev_q;
    logic       cmd_active;
    logic       hold_q;
    logic       err_set;
    logic       page0;
    logic       hit_low;
    logic       hit_high;
    logic       wr_cfg_low;
    logic       wr_cfg_high;
    logic [7:0] media_rd;

    // pin synchronisers
    hcr_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_link (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_link_good_pin),
        .o_level   (link_good_flag)
    );
    hcr_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_bale (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_bale_pin),
        .o_level   (bale_lvl)
    );
    hcr_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_ior (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_ior_n_pin),
        .o_level   (ior_n_lvl)
    );
    hcr_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_iow (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_iow_n_pin),
        .o_level   (iow_n_lvl)
    );

    // address decode; only page zero holds these registers (host selects it)
    assign page0    = (i_req.page == hcr_pkg::PAGE_ZERO);           // see (RL14)
    assign hit_low  = page0 && (i_req.addr == hcr_pkg::OFS_IO_AND_IRQ_SETUP);
    assign hit_high = page0 && (i_req.addr == hcr_pkg::OFS_MEDIA_AND_BUS_SETUP);

    // a write reaches the config register only straight after its own read
    assign wr_cfg_low  = i_req.wr && hit_low && armed_low_q;       // see (RL2)
    assign wr_cfg_high = i_req.wr && hit_high && armed_high_q;     // see (RL5)

    // arm on a read, disarm on any other access, so stale arming cannot leak
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            armed_low_q  <= 1'b0;
            armed_high_q <= 1'b0;
        end else if (i_req.rd || i_req.wr) begin
            armed_low_q  <= i_req.rd && hit_low;                    // see (RL15)
            armed_high_q <= i_req.rd && hit_high;                   // see (RL15)
        end
    end

    // unarmed writes are passed on as remote byte count writes
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_cnt_wr <= '0;
        end else begin
            o_cnt_wr.low_stb  <= i_req.wr && hit_low && !armed_low_q;   // see (RL3)
            o_cnt_wr.high_stb <= i_req.wr && hit_high && !armed_high_q; // see (RL6)
            if (i_req.wr && (hit_low || hit_high)) begin
                o_cnt_wr.data <= i_req.wdata;
            end
        end
    end

    // io_and_irq_setup: all eight bits writable
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            io_and_irq_setup_q <= hcr_pkg::IO_IRQ_RESET;
        end else if (wr_cfg_low) begin
            io_and_irq_setup_q <= i_req.wdata;                      // see (RL2)
        end
    end

    // media_and_bus_setup: writable fields, error flag set wins over clear
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            media_and_bus_setup_q <= hcr_pkg::MEDIA_RESET;
        end else begin
            if (wr_cfg_high) begin
                media_and_bus_setup_q[1:0] <= i_req.wdata[1:0];     // see (RL5)
                media_and_bus_setup_q[hcr_pkg::WAIT_TIMING_BIT] <=
                    i_req.wdata[hcr_pkg::WAIT_TIMING_BIT];
            end
            if (err_set) begin
                media_and_bus_setup_q[hcr_pkg::CYCLE_ERR_BIT] <= 1'b1;   // see (RL13)
            end else if (wr_cfg_high && i_req.wdata[hcr_pkg::CYCLE_ERR_BIT]) begin
                media_and_bus_setup_q[hcr_pkg::CYCLE_ERR_BIT] <= 1'b0;   // write one clears
            end
        end
    end

    // read view: live link bit, reserved bits forced to zero
    always_comb begin
        media_rd = media_and_bus_setup_q & hcr_pkg::MEDIA_WR_MASK;       // see (RL16)
        media_rd[hcr_pkg::CYCLE_ERR_BIT] = media_and_bus_setup_q[hcr_pkg::CYCLE_ERR_BIT];
        media_rd[hcr_pkg::LINK_GOOD_BIT] = link_good_flag;               // see (RL11)
    end

    // read data registered, valid the cycle after the read pulse
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_req.rd && (hit_low || hit_high);
            if (i_req.rd && hit_low) begin
                o_reg_rdata <= io_and_irq_setup_q;                  // see (RL1)
            end else if (i_req.rd && hit_high) begin
                o_reg_rdata <= media_rd;                            // see (RL4)
            end
        end
    end

    // io base decode from bits 3..0
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_io_base <= hcr_pkg::IO_BASE_HIGH;
        end else begin
            o_io_base <= (io_and_irq_setup_q[hcr_pkg::IO_BASE_SEL_HI] ?
                          hcr_pkg::IO_BASE_LOW : hcr_pkg::IO_BASE_HIGH) +
                         {2'b00, io_and_irq_setup_q[2:0], 5'h00};   // see (RL7)
        end
    end

    // interrupt line routing
    hcr_irq_route #(.LINES(8)) u_irq (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_request (i_irq_request),
        .i_sel     (io_and_irq_setup_q[hcr_pkg::IRQ_SEL_LSB +: 3]),  // see (RL8)
        .o_lines   (o_irq_lines)
    );

    // early fetch pulse: start the next read as soon as the previous one ends
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_early_fetch_req <= 1'b0;
        end else begin
            o_early_fetch_req <= i_port_read_done && i_remote_read_mode &&
                                 io_and_irq_setup_q[hcr_pkg::EARLY_FETCH_BIT];  // see (RL9)
        end
    end

    // medium select; undefined code 01 leaves coax off
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_media_sel       <= hcr_pkg::MEDIA_TWISTED;
            o_coax_enable_out <= 1'b0;
        end else begin
            o_media_sel <= media_and_bus_setup_q[hcr_pkg::MEDIA_SEL_LSB +: 2];
            unique case (media_and_bus_setup_q[hcr_pkg::MEDIA_SEL_LSB +: 2])
                hcr_pkg::MEDIA_COAX: o_coax_enable_out <= 1'b1;                // see (RL10)
                hcr_pkg::MEDIA_AUTO: o_coax_enable_out <= i_auto_coax_detect;  // see (RL10)
                default:             o_coax_enable_out <= 1'b0;                // see (RL10)
            endcase
        end
    end

    // edge history of the synchronised strobes
    assign cmd_active = !ior_n_lvl || !iow_n_lvl;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bale_prev_q <= 1'b0;
            cmd_prev_q  <= 1'b0;
        end else begin
            bale_prev_q <= bale_lvl;
            cmd_prev_q  <= cmd_active;
        end
    end

    // iochrdy hold: start point chosen by the timing bit, released when ready
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hold_q <= 1'b0;
        end else if (!i_need_wait || (cmd_prev_q && !cmd_active)) begin
            hold_q <= 1'b0;
        end else if (media_and_bus_setup_q[hcr_pkg::WAIT_TIMING_BIT]) begin
            if (bale_lvl && !bale_prev_q) begin
                hold_q <= 1'b1;                                     // see (RL12)
            end
        end else if (cmd_active && !cmd_prev_q) begin
            hold_q <= 1'b1;                                         // see (RL12)
        end
    end

    // host ended its strobe while we still held iochrdy low
    assign err_set = hold_q && i_need_wait && cmd_prev_q && !cmd_active;  // see (RL13)

    // open-drain iochrdy: only ever drives low
    assign o_iochrdy_out = 1'b0;
    assign o_iochrdy_oe  = hold_q;                                  // see (RL12)
endmodule

// ==== dv/hcr_regs_asserts.sv ====
// concurrent checks on the configuration register pair ports
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module hcr_regs_asserts (
    // clock and reset
    input wire logic                    i_sys_clk,
    input wire logic                    i_rst,
    // register port
    input wire hcr_pkg::hcr_req_type    i_req,
    input wire logic [7:0]              o_reg_rdata,
    input wire logic                    o_reg_rvalid,
    input wire hcr_pkg::hcr_cnt_wr_type o_cnt_wr,
    // decoded outputs and their causes
    input wire logic [9:0]              o_io_base,
    input wire logic [7:0]              o_irq_lines,
    input wire logic                    i_remote_read_mode,
    input wire logic                    i_port_read_done,
    input wire logic                    o_early_fetch_req,
    input wire logic [1:0]              o_media_sel,
    input wire logic                    o_coax_enable_out
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic arm_a_q;
    logic arm_b_q;
    wire logic p0 = i_req.page == 2'h0;
    // mirror of the read arming; any access re-decides it
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            arm_a_q <= 1'b0;
            arm_b_q <= 1'b0;
        end else if (i_req.rd || i_req.wr) begin
            arm_a_q <= i_req.rd && p0 && i_req.addr == 4'ha;
            arm_b_q <= i_req.rd && p0 && i_req.addr == 4'hb;
        end
    end
    read_answer_a: assert property (
        i_req.rd && p0 && i_req.addr[3:1] == 3'h5 |=> o_reg_rvalid)
        else $error("no read answer");
    low_redirect_a: assert property (
        i_req.wr && p0 && i_req.addr == 4'ha && !arm_a_q
        |=> o_cnt_wr.low_stb && o_cnt_wr.data == $past(i_req.wdata))
        else $error("low count miss");
    high_redirect_a: assert property (
        i_req.wr && p0 && i_req.addr == 4'hb && !arm_b_q
        |=> o_cnt_wr.high_stb && o_cnt_wr.data == $past(i_req.wdata))
        else $error("high count miss");
    armed_quiet_a: assert property (
        i_req.wr && (arm_a_q && i_req.addr == 4'ha || arm_b_q && i_req.addr == 4'hb)
        |=> !o_cnt_wr.low_stb && !o_cnt_wr.high_stb)
        else $error("strobe");
    io_base_map_a: assert property (
        o_reg_rvalid && $past(i_req.addr) == 4'ha
        |-> o_io_base == (o_reg_rdata[3] ? 10'h200 : 10'h300) + {o_reg_rdata[2:0], 5'h00})
        else $error("base");
    irq_onehot_a: assert property ($onehot0(o_irq_lines)) else $error("irq lines");
    early_cause_a: assert property (
        o_early_fetch_req |-> $past(i_port_read_done && i_remote_read_mode))
        else $error("early fetch");
    coax_map_a: assert property (
        o_media_sel != 2'h3 |-> o_coax_enable_out == (o_media_sel == 2'h2))
        else $error("coax enable");
    reserved_zero_a: assert property (
        o_reg_rvalid && $past(i_req.addr) == 4'hb |-> o_reg_rdata[7:6] == 2'h0 && !o_reg_rdata[3])
        else $error("reserved bits");
endmodule
bind hcr_config_regs hcr_regs_asserts u_chk (.i_sys_clk, .i_rst, .i_req, .o_reg_rdata,
    .o_reg_rvalid, .o_cnt_wr, .o_io_base, .o_irq_lines, .i_remote_read_mode,
    .i_port_read_done, .o_early_fetch_req, .o_media_sel, .o_coax_enable_out);

// ==== dv/hcr_host_model.sv ====
// host side model: register requests on page zero and the isa pins
// assumes requests change only just after a rising edge
`timescale 1ns/1ps
module hcr_host_model (
    // clock
    input  wire logic           i_sys_clk,
    // requests and pins
    output hcr_pkg::hcr_req_type o_req,
    output logic                o_bale_pin,
    output logic                o_ior_n_pin,
    output logic                o_iow_n_pin,
    output logic                o_link_good_pin
);
    // idle bus, page field always zero
    initial begin
        o_req = '0;
        {o_bale_pin, o_ior_n_pin, o_iow_n_pin, o_link_good_pin} = 4'b0111;
    end
    // one-cycle request; released data shows its inverse, not a held value
    task automatic req(input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_req <= '{rd: r, wr: !r, page: 2'h0, addr: a, wdata: d};
        @(posedge i_sys_clk);
        o_req <= '{rd: 1'b0, wr: 1'b0, page: 2'h0, addr: a, wdata: ~d};
    endtask
    // a config update is a read then the write as next access
    task automatic rd(input logic [3:0] a);
        req(1'b1, a, 8'h00);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req(1'b0, a, d);
    endtask
    task automatic pins(input logic [3:0] v);
        @(posedge i_sys_clk);
        {o_bale_pin, o_ior_n_pin, o_iow_n_pin, o_link_good_pin} <= v;
    endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the host configuration register pair
// assumes host model drives requests and pins; bench drives the rest
`timescale 1ns/1ps
module tb;
    logic i_sys_clk, i_rst, irq_req, rmode, rdone, auto_cx, need_wait;
    hcr_pkg::hcr_req_type    req;
    hcr_pkg::hcr_cnt_wr_type cnt;
    logic [7:0] rdata, irq_lines;
    logic [9:0] io_base;
    logic [1:0] media;
    logic rvalid, efetch, coax, oe, rdy_out, bale, ior_n, iow_n, link;
    int failures, checks_done, cyc, io_and_irq_setup, media_and_bus_setup, err, v;
    hcr_config_regs uut (.i_sys_clk, .i_rst, .i_req(req), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_cnt_wr(cnt), .o_io_base(io_base),
        .i_irq_request(irq_req), .o_irq_lines(irq_lines), .i_remote_read_mode(rmode),
        .i_port_read_done(rdone), .o_early_fetch_req(efetch), .i_auto_coax_detect(auto_cx),
        .i_link_good_pin(link), .o_media_sel(media), .o_coax_enable_out(coax),
        .i_bale_pin(bale), .i_ior_n_pin(ior_n), .i_iow_n_pin(iow_n), .i_need_wait(need_wait),
        .o_iochrdy_out(rdy_out), .o_iochrdy_oe(oe));
    hcr_host_model host (.i_sys_clk, .o_req(req), .o_bale_pin(bale), .o_ior_n_pin(ior_n),
        .o_iow_n_pin(iow_n), .o_link_good_pin(link));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // model view of the second register as read back
    function automatic logic [7:0] crb_exp();
        return 8'(media_and_bus_setup & 8'h13) | {2'h0, err[0], 2'h0, link, 2'h0};
    endfunction
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        host.rd(a);
        #1;
        chk({rvalid, rdata}, {1'b1, exp});
    endtask
    task automatic cfg_wr(input logic [3:0] a, input logic [7:0] d);
        host.rd(a);
        #1;
        host.wr(a, d);
        #1;
        chk({cnt.low_stb, cnt.high_stb}, 2'b00);
        if (a == 4'ha) io_and_irq_setup = d;
        else media_and_bus_setup = d;
        if (a == 4'hb && d[5]) err = 0;
    endtask
    task automatic wait_oe(input logic lv);
        // look one step after each edge so the launching edge's update is settled
        for (int i = 0; i < 20 && oe !== lv; i++) begin
            @(posedge i_sys_clk);
            #1;
        end
        chk({oe, rdy_out}, {lv, 1'b0});
    endtask
    // 50 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    // hang guard well above the expected run length
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        v = $urandom(68663);
        {i_rst, irq_req, rmode, rdone, need_wait} = 5'b10000;
        auto_cx = v[0];
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        rd_chk(4'ha, 8'h00);
        chk(io_base, 10'h300);
        rd_chk(4'hb, crb_exp());
        host.wr(4'ha, 8'h5a);
        #1 chk({cnt.low_stb, cnt.high_stb, cnt.data}, 10'h25a);
        host.wr(4'hb, 8'ha5);
        #1 chk({cnt.low_stb, cnt.high_stb, cnt.data}, 10'h1a5);
        host.rd(4'ha);
        host.rd(4'hc);
        #1 chk(rvalid, 1'b0);
        host.wr(4'ha, 8'h3c);
        #1 chk({cnt.low_stb, cnt.high_stb, cnt.data}, 10'h23c);
        $display("test redirect done");
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            irq_req <= v[4];
            cfg_wr(4'ha, {1'b0, 3'(i), 4'(v)});
            rd_chk(4'ha, 8'(io_and_irq_setup));
            chk(io_base, (io_and_irq_setup[3] ? 10'h200 : 10'h300) + 10'(io_and_irq_setup[2:0]) * 10'h20);
            // both request levels on every selected line
            repeat (2) begin
                chk(irq_lines, irq_req ? 8'h01 << i : 8'h00);
                irq_req <= !irq_req;
                repeat (2) @(posedge i_sys_clk);
                #1;
            end
        end
        // bit 7 with read mode, bit 7 without read mode, then bit 7 cleared
        cfg_wr(4'ha, 8'h80);
        for (int m = 2; m >= 0; m--) begin
            if (m == 0) cfg_wr(4'ha, 8'h00);
            @(posedge i_sys_clk);
            {rmode, rdone} <= {m != 1, 1'b1};
            @(posedge i_sys_clk);
            rdone <= 1'b0;
            #1 chk(efetch, m == 2);
        end
        $display("test first register done");
        for (int c = 0; c < 4; c++) begin
            @(posedge i_sys_clk);
            auto_cx <= v[c];
            cfg_wr(4'hb, 8'(c) | 8'hc8);
            repeat (2) @(posedge i_sys_clk);
            #1 chk({media, coax}, {2'(c), c == 2 || c == 3 && v[c]});
            rd_chk(4'hb, crb_exp());
        end
        cfg_wr(4'hb, 8'h00);
        @(posedge i_sys_clk);
        need_wait <= 1'b1;
        host.pins(4'b0011);
        wait_oe(1'b1);
        host.pins(4'b0111);
        repeat (6) @(posedge i_sys_clk);
        need_wait <= 1'b0;
        err = 1;
        rd_chk(4'hb, crb_exp());
        cfg_wr(4'hb, 8'h30);
        @(posedge i_sys_clk);
        need_wait <= 1'b1;
        host.pins(4'b1111);
        wait_oe(1'b1);
        need_wait <= 1'b0;
        wait_oe(1'b0);
        host.pins(4'b0110);
        repeat (6) @(posedge i_sys_clk);
        rd_chk(4'hb, crb_exp());
        $display("test second register done");
        print_verdict();
    end
endmodule
